// >>> rtl/thermo_pkg.sv
/*
  shared constants of the thermometer core: command codes, scratchpad layout,
  reset values, conversion timing and the check-byte polynomial.
  assumes a 40 MHz mclk; nothing else.
*/
package thermo_pkg;
  // function command codes
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_RD_SP = 8'hBE;
  localparam logic [7:0] CMD_WR_SP = 8'h4E;
  localparam logic [7:0] CMD_COPY_SP = 8'h48;
  localparam logic [7:0] CMD_RECALL = 8'hB8;
  // scratchpad byte indices
  localparam logic [3:0] SP_TEMP_LO = 4'h0;
  localparam logic [3:0] SP_TEMP_HI = 4'h1;
  localparam logic [3:0] SP_HIGH_THR = 4'h2;
  localparam logic [3:0] SP_LOW_THR = 4'h3;
  localparam logic [3:0] SP_CONFIG = 4'h4;
  localparam logic [3:0] SP_CHECK = 4'h8;
  localparam logic [3:0] SP_LAST = 4'h8;
  localparam logic [1:0] WR_LAST = 2'h2;
  // internal bytes 5..7, no fixed meaning
  localparam logic [7:0] SP_INT5 = 8'hFF;
  localparam logic [7:0] SP_INT6 = 8'h0C;
  localparam logic [7:0] SP_INT7 = 8'h10;
  // configuration byte layout
  localparam int CFG_RES_LSB = 5;
  localparam logic [4:0] CFG_ONES = 5'h1F;
  localparam logic [1:0] RES_12BIT = 2'h3;
  localparam logic [1:0] RES_MAX_SHIFT = 2'h3;
  // reset and factory values
  localparam logic [15:0] TEMP_POR = 16'h0550;
  localparam logic [7:0] NV_HIGH_DEF = 8'h7D;
  localparam logic [7:0] NV_LOW_DEF = 8'hC9;
  localparam logic [1:0] NV_RES_DEF = RES_12BIT;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  // identity and scratchpad bit counts
  localparam logic [6:0] ROM_BODY_BITS = 7'd56;
  localparam logic [6:0] SP_BODY_BITS = 7'd64;
  // check-byte polynomial x^8+x^5+x^4+1, reflected for lsb-first shifting
  localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
  // timing
  localparam int CLK_NS = 25;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_MAX_MS = 750;
  localparam int CONV_MAX_US = CONV_MAX_MS * 1000;
  localparam int US_CNT_W = 20;
endpackage

// >>> rtl/crc_if.sv
/*
  carrier between the core and its check-byte shifter.
  assumes the shifter is clocked by the same mclk as the core.
*/
`timescale 1ns/10ps
interface crc_if;
  logic clr;
  logic shift;
  logic din;
  logic [7:0] crc;
  modport lfsr (input clr, input shift, input din, output crc);
  modport user (output clr, output shift, output din, input crc);
endinterface

// >>> rtl/crc8_lfsr.sv
/*
  serial 8-bit check-byte generator, one bit per enabled cycle, lsb first.
  assumes clr and shift come from the core in the mclk domain.
*/
`timescale 1ns/10ps
module crc8_lfsr (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // shifter side
  crc_if.lfsr c
);
  logic [7:0] crc_q;
  logic [7:0] crc_d;
  logic fb;

  always_comb begin
    fb = c.din ^ crc_q[0];
    crc_d = crc_q;
    if (c.clr) begin
      crc_d = 8'h00;
    end else if (c.shift) begin
      crc_d = (crc_q >> 1) ^ (fb ? thermo_pkg::CRC_POLY_REFL : 8'h00);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      crc_q <= 8'h00;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign c.crc = crc_q;
endmodule

// >>> rtl/thermo_core.sv
/*
  thermometer core: conversion, scratchpad, nonvolatile copies, alarm flag,
  identity code and check bytes, behind the bus transaction layer.
  assumes the transaction layer delivers whole command and data bytes and
  asks for read bytes one at a time; all inputs but arst_n and nv_init_n are synchronous to mclk.
*/
`timescale 1ns/10ps
module thermo_core #(
  parameter int CONV_US = thermo_pkg::CONV_MAX_US,
  // arbitrary identity values
  parameter logic [7:0] FAMILY_CODE = 8'h5A,
  parameter logic [47:0] SERIAL_NUM = 48'h0000_1234_5678
) (
  // clock and resets
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic nv_init_n,
  // ROM layer events
  input wire logic rom_ok,
  input wire logic bus_reset,
  // function commands
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  output logic cmd_refused,
  // write data
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  // read data
  input wire logic rd_req,
  output logic rd_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  // sensor
  input wire logic [11:0] sensor_raw,
  // status
  output logic conv_busy,
  output logic alarm_flag,
  output logic [63:0] rom_code,
  output logic rom_code_valid
);
  if (CONV_US < 8 || CONV_US >= (1 << thermo_pkg::US_CNT_W)) begin : g_chk
    $error("CONV_US out of range");
  end
  typedef enum logic [1:0] {
    ST_INIT_CRC = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONVERT = 2'b11,
    ST_SP_CRC = 2'b10
  } state_t;
  localparam int DIV_W = $clog2(thermo_pkg::US_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(thermo_pkg::US_CYCLES - 1);
  localparam int UW = thermo_pkg::US_CNT_W;
  crc_if crc_c ();
  crc8_lfsr u_crc (
    .mclk(mclk),
    .arst_n(arst_n),
    .c(crc_c.lfsr)
  );
  // nonvolatile copies
  logic [7:0] nv_high_q, nv_high_d;
  logic [7:0] nv_low_q, nv_low_d;
  logic [1:0] nv_res_q, nv_res_d;
  // control and scratchpad state
  state_t state_q, state_d;
  logic [6:0] cnt_q, cnt_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [UW-1:0] us_q, us_d;
  logic [UW-1:0] conv_lim;
  logic [15:0] temp_q, temp_d;
  logic [7:0] high_q, high_d;
  logic [7:0] low_q, low_d;
  logic [1:0] res_q, res_d;
  logic alarm_q, alarm_d;
  logic session_q, session_d;
  logic wr_on_q, wr_on_d;
  logic [1:0] wr_idx_q, wr_idx_d;
  logic rd_on_q, rd_on_d;
  logic [3:0] rd_idx_q, rd_idx_d;
  logic [7:0] sp_crc_q, sp_crc_d;
  logic [7:0] rom_crc_q, rom_crc_d;
  logic rom_ok_q, rom_ok_d;
  logic rd_valid_q, rd_valid_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic refused_q, refused_d;
  logic copy_now;
  logic us_tick;
  logic [55:0] rom_body;
  logic [63:0] sp_body;
  logic [15:0] new_temp;
  logic signed [7:0] temp_int;
  // fixed bits around the resolution field
  function automatic logic [7:0] cfg_byte(input logic [1:0] res);
    cfg_byte = {1'b0, res, thermo_pkg::CFG_ONES};
  endfunction
  function automatic logic [7:0] sp_byte(input logic [3:0] idx, input logic [15:0] t,
                                         input logic [7:0] hi, input logic [7:0] lo,
                                         input logic [1:0] res, input logic [7:0] chk);
    unique case (idx)
      4'h0: sp_byte = t[7:0];
      4'h1: sp_byte = t[15:8];
      4'h2: sp_byte = hi;
      4'h3: sp_byte = lo;
      4'h4: sp_byte = cfg_byte(res);
      4'h5: sp_byte = thermo_pkg::SP_INT5;
      4'h6: sp_byte = thermo_pkg::SP_INT6;
      4'h7: sp_byte = thermo_pkg::SP_INT7;
      4'h8: sp_byte = chk;
      default: sp_byte = thermo_pkg::IDLE_BYTE;
    endcase
  endfunction
  assign rom_body = {SERIAL_NUM, FAMILY_CODE};
  assign sp_body = {thermo_pkg::SP_INT7, thermo_pkg::SP_INT6, thermo_pkg::SP_INT5,
                    cfg_byte(res_q), low_q, high_q, temp_q};
  // time limit shrinks by halves with resolution
  assign conv_lim = UW'(CONV_US >> (thermo_pkg::RES_MAX_SHIFT - res_q));
  assign us_tick = (state_q == ST_CONVERT) && (div_q == DIV_LAST);
  // sign extension over the top four bits
  assign new_temp = {{4{sensor_raw[11]}}, sensor_raw} &
                    (16'hFFFF << (thermo_pkg::RES_MAX_SHIFT - res_q));
  // integer part, sign aligned with threshold msb
  assign temp_int = new_temp[11:4];
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    div_d = div_q;
    us_d = us_q;
    temp_d = temp_q;
    high_d = high_q;
    low_d = low_q;
    res_d = res_q;
    alarm_d = alarm_q;
    session_d = session_q;
    wr_on_d = wr_on_q;
    wr_idx_d = wr_idx_q;
    rd_on_d = rd_on_q;
    rd_idx_d = rd_idx_q;
    sp_crc_d = sp_crc_q;
    rom_crc_d = rom_crc_q;
    rom_ok_d = rom_ok_q;
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    refused_d = 1'b0;
    copy_now = 1'b0;
    crc_c.clr = 1'b0;
    crc_c.shift = 1'b0;
    crc_c.din = 1'b0;
    // a completed ROM command opens a session
    if (rom_ok) begin
      session_d = 1'b1;
    end
    if (bus_reset) begin
      session_d = 1'b0;
      wr_on_d = 1'b0;
      rd_on_d = 1'b0;
    end
    unique case (state_q)
      ST_INIT_CRC: begin
        if (cnt_q == 7'd0) begin
          high_d = nv_high_q;
          low_d = nv_low_q;
          res_d = nv_res_q;
        end
        if (cnt_q < thermo_pkg::ROM_BODY_BITS) begin
          crc_c.shift = 1'b1;
          crc_c.din = rom_body[cnt_q[5:0]];
          cnt_d = cnt_q + 7'd1;
        end else begin
          rom_crc_d = crc_c.crc;
          rom_ok_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_CONVERT: begin
        div_d = us_tick ? '0 : div_q + DIV_W'(1);
        if (us_tick) begin
          us_d = us_q + UW'(1);
          if (us_q == conv_lim - UW'(1)) begin
            temp_d = new_temp;
            alarm_d = (temp_int > $signed(high_q)) || (temp_int < $signed(low_q));
            state_d = ST_IDLE;
          end
        end
      end
      ST_SP_CRC: begin
        // check byte over the eight bytes
        if (cnt_q < thermo_pkg::SP_BODY_BITS) begin
          crc_c.shift = 1'b1;
          crc_c.din = sp_body[cnt_q[5:0]];
          cnt_d = cnt_q + 7'd1;
        end else begin
          sp_crc_d = crc_c.crc;
          rd_on_d = 1'b1;
          rd_idx_d = thermo_pkg::SP_TEMP_LO;
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cmd_valid) begin
          // refuse without session or while busy
          if (!session_q) begin
            refused_d = 1'b1;
          end else begin
            session_d = 1'b0;
            wr_on_d = 1'b0;
            rd_on_d = 1'b0;
            unique case (cmd_code)
              thermo_pkg::CMD_CONVERT: begin
                div_d = '0;
                us_d = '0;
                state_d = ST_CONVERT;
              end
              // read starts after the check byte is ready
              thermo_pkg::CMD_RD_SP: begin
                crc_c.clr = 1'b1;
                cnt_d = 7'd0;
                state_d = ST_SP_CRC;
              end
              thermo_pkg::CMD_WR_SP: begin
                wr_on_d = 1'b1;
                wr_idx_d = 2'd0;
              end
              thermo_pkg::CMD_COPY_SP: copy_now = 1'b1;
              thermo_pkg::CMD_RECALL: begin
                high_d = nv_high_q;
                low_d = nv_low_q;
                res_d = nv_res_q;
              end
              default: refused_d = 1'b1;
            endcase
          end
        end else if (wr_valid && wr_on_q) begin
          unique case (wr_idx_q)
            2'd0: high_d = wr_data;
            2'd1: low_d = wr_data;
            default: res_d = wr_data[thermo_pkg::CFG_RES_LSB +: 2];
          endcase
          wr_idx_d = wr_idx_q + 2'd1;
          wr_on_d = (wr_idx_q != thermo_pkg::WR_LAST);
        end else if (rd_req && rd_on_q) begin
          // check byte sent regardless of any mismatch
          rd_valid_d = 1'b1;
          rd_data_d = sp_byte(rd_idx_q, temp_q, high_q, low_q, res_q, sp_crc_q);
          rd_idx_d = rd_idx_q + 4'd1;
          rd_on_d = (rd_idx_q != thermo_pkg::SP_LAST);
        end
      end
    endcase
    if (cmd_valid && state_q != ST_IDLE) begin
      refused_d = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_INIT_CRC;
      cnt_q <= 7'd0;
      div_q <= '0;
      us_q <= '0;
      temp_q <= thermo_pkg::TEMP_POR;
      high_q <= thermo_pkg::NV_HIGH_DEF;
      low_q <= thermo_pkg::NV_LOW_DEF;
      res_q <= thermo_pkg::RES_12BIT;
      alarm_q <= 1'b0;
      session_q <= 1'b0;
      wr_on_q <= 1'b0;
      wr_idx_q <= 2'd0;
      rd_on_q <= 1'b0;
      rd_idx_q <= 4'h0;
      sp_crc_q <= 8'h00;
      rom_crc_q <= 8'h00;
      rom_ok_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      refused_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      us_q <= us_d;
      temp_q <= temp_d;
      high_q <= high_d;
      low_q <= low_d;
      res_q <= res_d;
      alarm_q <= alarm_d;
      session_q <= session_d;
      wr_on_q <= wr_on_d;
      wr_idx_q <= wr_idx_d;
      rd_on_q <= rd_on_d;
      rd_idx_q <= rd_idx_d;
      sp_crc_q <= sp_crc_d;
      rom_crc_q <= rom_crc_d;
      rom_ok_q <= rom_ok_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
      refused_q <= refused_d;
    end
  end
  // nonvolatile store, untouched by arst_n
  always_comb begin
    nv_high_d = nv_high_q;
    nv_low_d = nv_low_q;
    nv_res_d = nv_res_q;
    if (copy_now) begin
      nv_high_d = high_q;
      nv_low_d = low_q;
      nv_res_d = res_q;
    end
  end
  always_ff @(posedge mclk or negedge nv_init_n) begin
    if (!nv_init_n) begin
      nv_high_q <= thermo_pkg::NV_HIGH_DEF;
      nv_low_q <= thermo_pkg::NV_LOW_DEF;
      nv_res_q <= thermo_pkg::NV_RES_DEF;
    end else begin
      nv_high_q <= nv_high_d;
      nv_low_q <= nv_low_d;
      nv_res_q <= nv_res_d;
    end
  end
  assign cmd_refused = refused_q;
  assign rd_ready = (state_q == ST_IDLE) && rd_on_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign conv_busy = (state_q == ST_CONVERT);
  assign alarm_flag = alarm_q;
  // identity with its check byte on top
  assign rom_code = {rom_crc_q, rom_body};
  assign rom_code_valid = rom_ok_q;
endmodule

// >>> bench/thermo_core_asserts.sv
/*
  port checker of the thermometer core, bound to thermo_core.
  assumes one mclk domain and active-low async arst_n.
*/
`timescale 1ns/10ps
module thermo_core_asserts #(
  parameter logic [7:0] FAMILY_CODE = 8'h5A
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // commands
  input wire logic cmd_valid,
  input wire logic cmd_refused,
  // reads
  input wire logic rd_req,
  input wire logic rd_ready,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  // status
  input wire logic conv_busy,
  input wire logic alarm_flag,
  input wire logic [63:0] rom_code,
  input wire logic rom_code_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_early_refused: assert property (
    cmd_valid && !rom_code_valid |=> cmd_refused) else $error("early command taken");
  a_refuse_cause: assert property (
    cmd_refused |-> $past(cmd_valid)) else $error("refusal without command");
  a_busy_refused: assert property (
    cmd_valid && conv_busy |=> cmd_refused) else $error("command taken while busy");
  a_busy_no_read: assert property (
    conv_busy |-> !rd_ready) else $error("read open during conversion");
  a_read_answer: assert property (
    rd_req && rd_ready && !cmd_valid |=> rd_valid) else $error("read not answered");
  a_read_stray: assert property (
    !(rd_req && rd_ready) |=> !rd_valid) else $error("read data without request");
  a_data_held: assert property (
    $changed(rd_data) |-> rd_valid) else $error("read data moved alone");
  a_alarm_at_end: assert property (
    $changed(alarm_flag) |-> $fell(conv_busy)) else $error("alarm moved mid conversion");
  a_conv_min: assert property (
    $rose(conv_busy) |-> conv_busy[*8]) else $error("conversion too short");
  a_conv_cause: assert property (
    $rose(conv_busy) |-> $past(cmd_valid) || $past(cmd_valid, 2))
    else $error("conversion without command");
  a_id_family: assert property (
    rom_code_valid |-> rom_code[7:0] == FAMILY_CODE) else $error("family byte wrong");
  a_id_kept: assert property (
    rom_code_valid |=> rom_code_valid && $stable(rom_code)) else $error("identity moved");
endmodule

bind thermo_core thermo_core_asserts #(.FAMILY_CODE(FAMILY_CODE)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_refused(cmd_refused),
  .rd_req(rd_req), .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
  .conv_busy(conv_busy), .alarm_flag(alarm_flag), .rom_code(rom_code),
  .rom_code_valid(rom_code_valid)
);

// >>> bench/thermo_master.sv
/*
  bus-master model: sessions, function commands, scratchpad write and read.
  assumes the core samples on rising mclk; this model drives on falling mclk.
*/
`timescale 1ns/10ps
module thermo_master (
  // clock
  input wire logic mclk,
  // requests
  output logic rom_ok,
  output logic bus_reset,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_req,
  // answers
  input wire logic cmd_refused,
  input wire logic rd_ready,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data
);
  logic [7:0] sp [9];
  logic [7:0] sp_crc;
  int n_valid;
  initial begin
    rom_ok = 1'b0;
    bus_reset = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    rd_req = 1'b0;
  end
  function automatic logic [7:0] crc8(input logic [63:0] d, input int nbits);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? thermo_pkg::CRC_POLY_REFL : 8'h00);
    end
    return c;
  endfunction
  // session first when rom is nonzero; rom 2 closes it again
  task automatic cmd(input logic [7:0] c, input int rom, output logic refused);
    @(negedge mclk);
    rom_ok = (rom != 0);
    if (rom == 2) begin
      @(negedge mclk);
      rom_ok = 1'b0;
      bus_reset = 1'b1;
    end
    @(negedge mclk);
    rom_ok = 1'b0;
    bus_reset = 1'b0;
    cmd_valid = 1'b1;
    cmd_code = c;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_code = ~c;
    refused = cmd_refused;
    @(negedge mclk);
    refused = refused | cmd_refused;
  endtask
  // all three bytes in one sequence
  task automatic wr3(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] cfg);
    logic r;
    logic [23:0] b;
    b = {cfg, lo, hi};
    cmd(thermo_pkg::CMD_WR_SP, 1, r);
    for (int i = 0; i < 3; i++) begin
      @(negedge mclk);
      wr_valid = 1'b1;
      wr_data = b[i*8 +: 8];
    end
    @(negedge mclk);
    wr_valid = 1'b0;
    wr_data = ~cfg;
  endtask
  task automatic rd_sp(input bit fast);
    logic r;
    logic [63:0] pk;
    n_valid = 0;
    cmd(thermo_pkg::CMD_RD_SP, 1, r);
    for (int w = 0; w < 200 && !rd_ready; w++) @(negedge mclk);
    @(negedge mclk);
    rd_req = 1'b1;
    for (int i = 0; i < 9; i++) begin
      @(negedge mclk);
      sp[i] = rd_data;
      n_valid += rd_valid;
      rd_req = fast && (i < 8);
      if (!fast && i < 8) begin
        @(negedge mclk);
        rd_req = 1'b1;
      end
    end
    for (int i = 0; i < 8; i++) pk[i*8 +: 8] = sp[i];
    sp_crc = crc8(pk, 64);
  endtask
endmodule

// >>> bench/thermometer_scratchpad_alarm_rom_tb_top.sv
/*
  self-checking bench of the thermometer core with a bus-master model.
  assumes the checker is bound by its own file.
*/
`timescale 1ns/10ps
module thermometer_scratchpad_alarm_rom_tb_top;
  localparam int CONV = 64;
  localparam logic [7:0] FAMILY = 8'hA3; // arbitrary value
  logic mclk = 1'b0;
  logic arst_n, nv_init_n, rom_ok, bus_reset, cmd_valid, cmd_refused;
  logic wr_valid, rd_req, rd_ready, rd_valid, conv_busy, alarm_flag, rom_code_valid;
  logic [7:0] cmd_code, wr_data, rd_data;
  logic [11:0] sensor_raw;
  logic [63:0] rom_code;
  int failures = 0;
  int n_compared = 0;
  always #12.5 mclk = ~mclk;
  thermo_core #(.CONV_US(CONV), .FAMILY_CODE(FAMILY)) u_dut (
    .mclk(mclk), .arst_n(arst_n), .nv_init_n(nv_init_n), .rom_ok(rom_ok),
    .bus_reset(bus_reset), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_refused(cmd_refused), .wr_valid(wr_valid), .wr_data(wr_data),
    .rd_req(rd_req), .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .sensor_raw(sensor_raw), .conv_busy(conv_busy), .alarm_flag(alarm_flag),
    .rom_code(rom_code), .rom_code_valid(rom_code_valid)
  );
  thermo_master u_master (
    .mclk(mclk), .rom_ok(rom_ok), .bus_reset(bus_reset), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req),
    .cmd_refused(cmd_refused), .rd_ready(rd_ready), .rd_valid(rd_valid),
    .rd_data(rd_data)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wait_id();
    for (int w = 0; w < 100 && !rom_code_valid; w++) @(negedge mclk);
    check(rom_code_valid, 1'b1);
  endtask
  task automatic chk_sp(input logic [39:0] e);
    for (int i = 0; i < 5; i++) check(u_master.sp[i], e[i*8 +: 8]);
    check(u_master.sp_crc, u_master.sp[8]);
    check(16'(u_master.n_valid), 16'h0009);
    check(rd_ready, 1'b0);
  endtask
  task automatic conv(output int n);
    logic r;
    u_master.cmd(thermo_pkg::CMD_CONVERT, 1, r);
    check(r, 1'b0);
    u_master.cmd(thermo_pkg::CMD_RD_SP, 1, r);
    check(r, 1'b1);
    n = 5;
    while (conv_busy && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    check(conv_busy, 1'b0);
  endtask
  task automatic t_early();
    logic r;
    u_master.cmd(thermo_pkg::CMD_CONVERT, 0, r);
    check(r, 1'b1);
    wait_id();
    u_master.cmd(thermo_pkg::CMD_CONVERT, 0, r);
    check(r, 1'b1);
    u_master.cmd(thermo_pkg::CMD_CONVERT, 2, r);
    check(r, 1'b1);
    u_master.cmd(8'hA5, 1, r);
    check(r, 1'b1);
  endtask
  task automatic t_por();
    u_master.rd_sp(1);
    chk_sp(40'h7FC97D0550);
    check(u_master.crc8(rom_code, 64), 16'h0000);
    check(rom_code[7:0], FAMILY);
  endtask
  task automatic t_res();
    int n;
    sensor_raw = 12'h191;
    for (int r = 0; r < 4; r++) begin
      u_master.wr3(8'h7D, 8'hC9, {1'b1, r[1:0], 5'h00});
      conv(n);
      check(n >= (CONV >> (3 - r)) * 40 - 3 && n <= (CONV >> (3 - r)) * 40 + 3, 1'b1);
      u_master.rd_sp(r[0]);
      check(16'(u_master.n_valid), 16'h0009);
      check({u_master.sp[1], u_master.sp[0]}, 16'h0191 & (16'hFFFF << (3 - r)));
      check(u_master.sp[4], {1'b0, r[1:0], 5'h1F});
    end
  endtask
  task automatic t_alarm();
    logic [59:0] s = {12'hF5E, 12'hF60, 12'h7D0, 12'h148, 12'hC90};
    logic [4:0] a = 5'b10101;
    int n;
    u_master.wr3(8'h14, 8'hF6, 8'h60);
    for (int i = 0; i < 5; i++) begin
      sensor_raw = s[i*12 +: 12];
      conv(n);
      check(alarm_flag, a[i]);
      u_master.rd_sp(0);
      check(16'(u_master.n_valid), 16'h0009);
      check({u_master.sp[1], u_master.sp[0]}, {{4{sensor_raw[11]}}, sensor_raw});
    end
  endtask
  task automatic t_copy();
    logic r;
    u_master.wr3(8'h33, 8'h11, 8'h20);
    u_master.cmd(thermo_pkg::CMD_COPY_SP, 1, r);
    check(r, 1'b0);
    u_master.wr3(8'h44, 8'h22, 8'h40);
    @(negedge mclk);
    arst_n = 1'b0;
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    wait_id();
    u_master.rd_sp(1);
    chk_sp(40'h3F11330550);
    u_master.wr3(8'h55, 8'h66, 8'h00);
    u_master.cmd(thermo_pkg::CMD_RECALL, 1, r);
    check(r, 1'b0);
    u_master.rd_sp(0);
    chk_sp(40'h3F11330550);
  endtask
  initial begin
    arst_n = 1'b0;
    nv_init_n = 1'b0;
    sensor_raw = 12'h000;
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    nv_init_n = 1'b1;
    t_early();
    t_por();
    t_res();
    t_alarm();
    t_copy();
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    print_verdict();
  end
endmodule
